// ==== verilog/clock_output_control_regs.v ====
// control and identification bytes 2..7 of a multi-output clock synthesizer, with output gating
// assumes a serial protocol engine hands over decoded single-byte writes and reads
// Operation
// RULE1: each power-down drive bit (pair bit 7, cpu pairs bits 5..3 of byte 2) floats the pair in power-down when set; bit 5 also floats cpu pair 3.
// RULE2: byte 2 bit 6 set floats the serial reference pair while the halt is active, else it stays driven.
// RULE3: byte 3 bit 7 (reset 1) lets the software halt stop enabled bus clocks on clean boundaries; when 0 only the pin does.
// RULE4: byte 3 bits 6..0 enable bus clocks 6..0, all enabled after reset.
// RULE5: byte 4 bit 7 picks high drive at 0 for the usb clock, bit 6 enables it.
// RULE6: byte 4 bits 2..0 enable the free-running bus clocks, all enabled after reset.
// RULE7: byte 4 bits 5..3 make each free-running bus clock stop with the halt pin when set, free after reset.
// RULE8: byte 5 bit 6 enables cpu pair 3, floated when 0, enabled after reset.
// RULE9: byte 5 bit 5 selects 66 MHz at 0 or the 48 MHz video mode at 1 on the shared output.
// RULE10: byte 6 bit 5 puts the frequency-select inputs in test mode when set.
// RULE11: byte 6 bit 4 picks 100 MHz at 0 or 200 MHz at 1 for the serial reference pair.
// RULE12: byte 6 bit 2 turns spread spectrum on, off after reset.
// RULE13: display, 66 MHz and reference enables are active high and reset to 1.
// RULE14: byte 6 bit 7 enables test clock mode; bits 6 and 3 are reserved and read zero.
// RULE15: byte 7 is read-only, revision code high nibble and vendor code low nibble.
// RULE16: access is one byte per transaction, the command byte 100xxxxx marks it and bits 6..0 give the offset.
// RULE17: a driven cpu pair in power-down holds true high at twice the current and leaves complement undriven.
`timescale 1ns/100ps
`default_nettype none
`include "clock_output_control_map.vh"
module clock_output_control_regs #(
  parameter [3:0] REVISION_CODE = 4'h5, // arbitrary value
  parameter [3:0] VENDOR_CODE = 4'hA, // arbitrary value
  parameter BUS_CLOCKS = 7,
  parameter FREERUN_CLOCKS = 3,
  parameter CPU_PAIRS = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // byte access from the serial engine
  input wire [7:0] command,
  input wire writeStrobe,
  input wire [7:0] writeData,
  input wire readStrobe,
  output reg [7:0] readData,
  output reg readValid,
  output wire commandAccepted,
  // pins
  input wire power_down_pin,
  input wire bus_clock_halt_pin,
  // per-output bus clock gating
  output reg [BUS_CLOCKS-1:0] busClockRun,
  output reg [BUS_CLOCKS-1:0] busClockEnable,
  output reg [FREERUN_CLOCKS-1:0] freerunBusClockRun,
  // cpu pairs
  output wire [CPU_PAIRS-1:0] cpuTrueOe,
  output wire [CPU_PAIRS-1:0] cpuCompOe,
  output wire [CPU_PAIRS-1:0] cpuTrueHoldHigh,
  output wire [CPU_PAIRS-1:0] cpuDoubleCurrent,
  // serial reference pair
  output wire srcTrueOe,
  output wire srcCompOe,
  output wire srcTrueHoldHigh,
  output wire srcDoubleCurrent,
  output reg srcFreq200,
  // other output controls
  output reg usbEnable,
  output reg usbHighDrive,
  output reg display48Enable,
  output reg [4:0] sixtySixEnable,
  output reg video48Mode,
  output reg [1:0] refEnable,
  output reg freqSelectTest,
  output reg spreadOn,
  output reg testClockMode
);
  reg [7:0] pairPdDrive;
  reg [7:0] busStopEnable;
  reg [7:0] usbFreerun;
  reg [7:0] midFreqEnable;
  reg [7:0] modeRef;
  wire powerDown;
  wire haltPin;
  wire haltActive;
  wire powerDownN;
  wire haltPinN;
  wire [5:0] byteSel;
  reg [7:0] readMux;
  reg haltAligned;
  wire [CPU_PAIRS-1:0] cpuEnable;
  wire [CPU_PAIRS-1:0] cpuPdTri;

  // command byte check
  function isByteOp;
    input [7:0] cmd;
    begin
      isByteOp = ((cmd & `CMD_BYTE_OP_MASK) == `CMD_BYTE_OP_CODE);
    end
  endfunction

  // one-hot pick of the addressed byte: bytes 2..7 from bit 0 up
  function [5:0] byteSelect;
    input [7:0] cmd;
    begin
      byteSelect = 6'h00;
      if (isByteOp(cmd)) begin
        case (cmd[6:0])
          `OFS_PAIR_PD_DRIVE: byteSelect = 6'h01;
          `OFS_BUS_STOP_EN: byteSelect = 6'h02;
          `OFS_USB_FREERUN: byteSelect = 6'h04;
          `OFS_MID_FREQ_EN: byteSelect = 6'h08;
          `OFS_MODE_REF: byteSelect = 6'h10;
          `OFS_MAKER_REV: byteSelect = 6'h20;
          default: byteSelect = 6'h00;
        endcase
      end
    end
  endfunction

  assign byteSel = byteSelect(command); // RULE16
  assign commandAccepted = isByteOp(command); // RULE16

  // pins are active low
  pin_sync #(.RESET_LEVEL(1'b1)) pdSync (
    .clk(clk),
    .rst(rst),
    .pinIn(power_down_pin),
    .level(powerDownN)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) haltSync (
    .clk(clk),
    .rst(rst),
    .pinIn(bus_clock_halt_pin),
    .level(haltPinN)
  );
  assign powerDown = !powerDownN;
  assign haltPin = !haltPinN;
  // software stop: halt reaches bus clocks one registered step later, never mid-pulse
  always @(posedge clk) begin
    if (rst)
      haltAligned <= 1'b0;
    else
      haltAligned <= haltPin;
  end
  // stop bit clear: the pin alone halts, straight through
  assign haltActive = busStopEnable[`B3_SW_STOP_EN] ? haltAligned : haltPin; // RULE3

  // register writes
  always @(posedge clk) begin
    if (rst) begin
      pairPdDrive <= `RST_PAIR_PD_DRIVE;
      busStopEnable <= `RST_BUS_STOP_EN;
      usbFreerun <= `RST_USB_FREERUN;
      midFreqEnable <= `RST_MID_FREQ_EN;
      modeRef <= `RST_MODE_REF;
    end else if (writeStrobe) begin // RULE16
      if (byteSel[0])
        pairPdDrive <= writeData & `WMASK_PAIR_PD_DRIVE; // RULE1
      if (byteSel[1])
        busStopEnable <= writeData; // RULE4
      if (byteSel[2])
        usbFreerun <= writeData; // RULE6
      if (byteSel[3])
        midFreqEnable <= writeData; // RULE13
      if (byteSel[4])
        modeRef <= writeData & `WMASK_MODE_REF; // RULE14
      // identification byte (byteSel[5]) has no write path
    end
  end

  // read-back value of the addressed byte; unmapped offsets read zero
  always @* begin
    case (byteSel)
      6'h01: readMux = pairPdDrive;
      6'h02: readMux = busStopEnable;
      6'h04: readMux = usbFreerun;
      6'h08: readMux = midFreqEnable;
      6'h10: readMux = modeRef;
      6'h20: readMux = {REVISION_CODE, VENDOR_CODE}; // RULE15
      default: readMux = 8'h00;
    endcase
  end

  // register reads
  always @(posedge clk) begin
    if (rst) begin
      readData <= 8'h00;
      readValid <= 1'b0;
    end else begin
      readValid <= readStrobe && commandAccepted; // RULE16
      if (readStrobe && commandAccepted)
        readData <= readMux;
    end
  end

  // bus clock gating
  genvar i;
  generate
    for (i = 0; i < BUS_CLOCKS; i = i + 1) begin : busGate
      always @(posedge clk) begin
        if (rst) begin
          busClockEnable[i] <= 1'b1;
          busClockRun[i] <= 1'b1;
        end else begin
          busClockEnable[i] <= busStopEnable[i]; // RULE4
          busClockRun[i] <= busStopEnable[i] && !haltActive && !powerDown; // RULE3
        end
      end
    end
    for (i = 0; i < FREERUN_CLOCKS; i = i + 1) begin : freeGate
      always @(posedge clk) begin
        if (rst)
          freerunBusClockRun[i] <= 1'b1;
        else
          freerunBusClockRun[i] <= usbFreerun[i] && !powerDown && // RULE6
            !(usbFreerun[`B4_FREERUN_STOPPABLE_LO + i] && haltPin); // RULE7
      end
    end
  endgenerate

  // cpu pairs
  assign cpuEnable = {midFreqEnable[`B5_CPU3_EN], {(CPU_PAIRS-1){1'b1}}}; // RULE8
  assign cpuPdTri = {pairPdDrive[`B2_CPU_PD_TRI_HI],
                     pairPdDrive[`B2_CPU_PD_TRI_HI:`B2_CPU_PD_TRI_LO]}; // RULE1
  generate
    for (i = 0; i < CPU_PAIRS; i = i + 1) begin : cpuPair
      pair_drive_ctrl pairCtl (
        .clk(clk),
        .rst(rst),
        .enable(cpuEnable[i]),
        .powerDown(powerDown),
        .pdTristate(cpuPdTri[i]), // RULE1
        .halted(1'b0),
        .haltTristate(1'b0),
        .trueOe(cpuTrueOe[i]),
        .compOe(cpuCompOe[i]),
        .trueHoldHigh(cpuTrueHoldHigh[i]), // RULE17
        .doubleCurrent(cpuDoubleCurrent[i]) // RULE17
      );
    end
  endgenerate

  pair_drive_ctrl srcPair (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .powerDown(powerDown),
    .pdTristate(pairPdDrive[`B2_SRC_PD_TRI]), // RULE1
    .halted(haltPin),
    .haltTristate(pairPdDrive[`B2_SRC_STOP_TRI]), // RULE2
    .trueOe(srcTrueOe),
    .compOe(srcCompOe),
    .trueHoldHigh(srcTrueHoldHigh),
    .doubleCurrent(srcDoubleCurrent)
  );

  // static output controls
  always @(posedge clk) begin
    if (rst) begin
      usbEnable <= 1'b1;
      usbHighDrive <= 1'b1;
      display48Enable <= 1'b1;
      sixtySixEnable <= 5'h1F;
      video48Mode <= 1'b0;
      refEnable <= 2'h3;
      freqSelectTest <= 1'b0;
      spreadOn <= 1'b0;
      testClockMode <= 1'b0;
      srcFreq200 <= 1'b0;
    end else begin
      usbEnable <= usbFreerun[`B4_USB_EN]; // RULE5
      usbHighDrive <= !usbFreerun[`B4_USB_NORMAL_DRIVE]; // RULE5
      display48Enable <= midFreqEnable[`B5_DISPLAY_EN]; // RULE13
      sixtySixEnable <= midFreqEnable[`B5_SIXTY_SIX_EN_HI:0]; // RULE13
      video48Mode <= midFreqEnable[`B5_VIDEO_MODE]; // RULE9
      refEnable <= modeRef[`B6_REF_EN_HI:0]; // RULE13
      freqSelectTest <= modeRef[`B6_FREQ_SEL_TEST]; // RULE10
      spreadOn <= modeRef[`B6_SPREAD_ON]; // RULE12
      testClockMode <= modeRef[`B6_TEST_CLOCK]; // RULE14
      srcFreq200 <= modeRef[`B6_SRC_200MHZ]; // RULE11
    end
  end
endmodule // clock_output_control_regs
`default_nettype wire

// ==== verilog/clock_output_control_map.vh ====
// register offsets, field positions, reset values and timing for the clock output control bytes
// assumes byte-wide access with a seven-bit offset from the serial command byte
`ifndef CLOCK_OUTPUT_CONTROL_MAP_VH
`define CLOCK_OUTPUT_CONTROL_MAP_VH

// byte offsets (command byte bits 6..0)
`define OFS_PAIR_PD_DRIVE 7'h02
`define OFS_BUS_STOP_EN 7'h03
`define OFS_USB_FREERUN 7'h04
`define OFS_MID_FREQ_EN 7'h05
`define OFS_MODE_REF 7'h06
`define OFS_MAKER_REV 7'h07

// command byte: upper three bits mark a byte operation
`define CMD_BYTE_OP_MASK 8'hE0
`define CMD_BYTE_OP_CODE 8'h80

// reset values
`define RST_PAIR_PD_DRIVE 8'h00
`define RST_BUS_STOP_EN 8'hFF
`define RST_USB_FREERUN 8'h47
`define RST_MID_FREQ_EN 8'hDF
`define RST_MODE_REF 8'h03

// writable bit masks; reserved bits read as zero
`define WMASK_PAIR_PD_DRIVE 8'hF8
`define WMASK_MODE_REF 8'hB7

// byte 2 fields
`define B2_SRC_PD_TRI 7
`define B2_SRC_STOP_TRI 6
`define B2_CPU_PD_TRI_HI 5
`define B2_CPU_PD_TRI_LO 3
// byte 3 fields
`define B3_SW_STOP_EN 7
`define B3_BUS_EN_HI 6
// byte 4 fields
`define B4_USB_NORMAL_DRIVE 7
`define B4_USB_EN 6
`define B4_FREERUN_STOPPABLE_HI 5
`define B4_FREERUN_STOPPABLE_LO 3
`define B4_FREERUN_EN_HI 2
// byte 5 fields
`define B5_DISPLAY_EN 7
`define B5_CPU3_EN 6
`define B5_VIDEO_MODE 5
`define B5_SIXTY_SIX_EN_HI 4
// byte 6 fields
`define B6_TEST_CLOCK 7
`define B6_FREQ_SEL_TEST 5
`define B6_SRC_200MHZ 4
`define B6_SPREAD_ON 2
`define B6_REF_EN_HI 1

// input filter length
`define PIN_SYNC_STAGES 3

`endif

// ==== verilog/pin_sync.v ====
// three-stage synchroniser for a pin input; a change counts once stages two and three agree
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pin and filtered level
  input wire pinIn,
  output reg level
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk) begin
    if (rst) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ==== verilog/pair_drive_ctrl.v ====
// drive decision for one differential clock pair
// assumes power-down and halt levels already synchronised
`timescale 1ns/100ps
`default_nettype none
module pair_drive_ctrl (
  // clock and reset
  input wire clk,
  input wire rst,
  // conditions
  input wire enable,
  input wire powerDown,
  input wire pdTristate,
  input wire halted,
  input wire haltTristate,
  // pad controls
  output reg trueOe,
  output reg compOe,
  output reg trueHoldHigh,
  output reg doubleCurrent
);
  always @(posedge clk) begin
    if (rst) begin
      trueOe <= 1'b0;
      compOe <= 1'b0;
      trueHoldHigh <= 1'b0;
      doubleCurrent <= 1'b0;
    end else if (!enable) begin
      trueOe <= 1'b0;
      compOe <= 1'b0;
      trueHoldHigh <= 1'b0;
      doubleCurrent <= 1'b0;
    end else if (powerDown) begin
      // parked: true held high at twice the current, complement undriven; pdTristate set floats both
      trueOe <= !pdTristate;
      compOe <= 1'b0;
      trueHoldHigh <= !pdTristate;
      doubleCurrent <= !pdTristate;
    end else if (halted) begin
      trueOe <= !haltTristate;
      compOe <= !haltTristate;
      trueHoldHigh <= 1'b0;
      doubleCurrent <= 1'b0;
    end else begin
      trueOe <= 1'b1;
      compOe <= 1'b1;
      trueHoldHigh <= 1'b0;
      doubleCurrent <= 1'b0;
    end
  end
endmodule // pair_drive_ctrl
`default_nettype wire

// ==== tb/output_ctrl_monitor.sv ====
// assertions on byte access and decoded output controls
// assumes binding to the register block, one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module output_ctrl_monitor #(
  parameter [3:0] REVISION_CODE = 4'h5,
  parameter [3:0] VENDOR_CODE = 4'hA,
  parameter BUS_CLOCKS = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte access
  input wire logic [7:0] command,
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic readStrobe,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic commandAccepted,
  // decoded controls
  input wire logic [BUS_CLOCKS-1:0] busClockEnable,
  input wire logic usbHighDrive,
  input wire logic video48Mode,
  input wire logic srcFreq200,
  input wire logic spreadOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rdGo = readStrobe && commandAccepted;
  a_byte_op_decode: assert property (commandAccepted == (command[7:5] == 3'h4))
    else $error("accept decode wrong");
  a_read_answer: assert property (rdGo |=> readValid)
    else $error("read not answered");
  a_valid_cause: assert property (readValid |-> $past(rdGo))
    else $error("stray read valid");
  a_id_read: assert property (readStrobe && command == 8'h87 |=>
    readData == {REVISION_CODE, VENDOR_CODE}) else $error("id byte wrong");
  a_unmapped_zero: assert property (readStrobe && command == 8'h88 |=> readData == 8'h00)
    else $error("unmapped read not zero");
  a_spread_follow: assert property (writeStrobe && command == 8'h86 |-> ##2
    spreadOn == $past(writeData[2], 2)) else $error("spread not updated");
  a_src_freq: assert property (writeStrobe && command == 8'h86 |-> ##2
    srcFreq200 == $past(writeData[4], 2)) else $error("ref freq not updated");
  a_video_mode: assert property (writeStrobe && command == 8'h85 |-> ##2
    video48Mode == $past(writeData[5], 2)) else $error("video mode not updated");
  a_bus_enable: assert property (writeStrobe && command == 8'h83 |-> ##2
    busClockEnable == $past(writeData[BUS_CLOCKS-1:0], 2)) else $error("bus enables wrong");
  a_usb_drive: assert property (writeStrobe && command == 8'h84 |-> ##2
    usbHighDrive != $past(writeData[7], 2)) else $error("usb drive wrong");
  cover property (rdGo && command == 8'h87);
  cover property (writeStrobe && command == 8'h86);
  cover property (writeStrobe && !commandAccepted);
endmodule // output_ctrl_monitor
`default_nettype wire

// ==== tb/byte_access_host.sv ====
// host model handing single-byte accesses to the register block
// assumes one task call at a time from the bench
`timescale 1ns/100ps
`default_nettype none
module byte_access_host (
  // clock
  input wire logic clk,
  // byte access
  output var logic [7:0] command = 8'h00,
  output var logic writeStrobe = 1'b0,
  output var logic [7:0] writeData = 8'h00,
  output var logic readStrobe = 1'b0
);
  // one access; released command and data lines show the inverse of the last value, both strobes drop
  task automatic put(input logic [7:0] c, input logic [7:0] d, input logic w);
    @(posedge clk);
    #1;
    command = c;
    writeData = d;
    writeStrobe = w;
    readStrobe = !w;
    @(posedge clk);
    #1;
    command = ~c;
    writeData = ~d;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
  endtask
endmodule // byte_access_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the clock output control bytes
// assumes the host model drives accesses and the monitor is bound
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  localparam logic [3:0] VEND = 4'hA; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_down_pin = 1'b1;
  logic bus_clock_halt_pin = 1'b1;
  wire logic [7:0] command, writeData, readData;
  wire logic writeStrobe, readStrobe, readValid, commandAccepted;
  wire logic [6:0] busClockRun, busClockEnable;
  wire logic [2:0] freerunBusClockRun;
  wire logic [3:0] cpuTrueOe, cpuCompOe, cpuTrueHoldHigh, cpuDoubleCurrent;
  wire logic srcTrueOe, srcCompOe, srcTrueHoldHigh, srcDoubleCurrent, srcFreq200;
  wire logic usbEnable, usbHighDrive, display48Enable, video48Mode;
  wire logic freqSelectTest, spreadOn, testClockMode;
  wire logic [4:0] sixtySixEnable;
  wire logic [1:0] refEnable;
  int nMismatch = 0;
  int numChecks = 0;
  wire logic [21:0] ctlVec = {busClockEnable, usbEnable, usbHighDrive, display48Enable,
    sixtySixEnable, video48Mode, refEnable, freqSelectTest, spreadOn, testClockMode, srcFreq200};
  always #50 clk = ~clk;
  clock_output_control_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEND)) i_dut (
    .clk, .rst, .command, .writeStrobe, .writeData, .readStrobe, .readData, .readValid,
    .commandAccepted, .power_down_pin, .bus_clock_halt_pin, .busClockRun, .busClockEnable,
    .freerunBusClockRun, .cpuTrueOe, .cpuCompOe, .cpuTrueHoldHigh, .cpuDoubleCurrent,
    .srcTrueOe, .srcCompOe, .srcTrueHoldHigh, .srcDoubleCurrent, .srcFreq200, .usbEnable,
    .usbHighDrive, .display48Enable, .sixtySixEnable, .video48Mode, .refEnable,
    .freqSelectTest, .spreadOn, .testClockMode);
  byte_access_host i_host (.clk, .command, .writeStrobe, .writeData, .readStrobe);
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic reg_read(input logic [7:0] ofs, input logic [7:0] exp);
    i_host.put(8'h80 | ofs, 8'h00, 1'b0);
    check({readValid, readData}, {1'h1, exp}, "register read");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    nMismatch++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    reg_read(8'h02, 8'h00);
    reg_read(8'h03, 8'hFF);
    reg_read(8'h04, 8'h47);
    reg_read(8'h05, 8'hDF);
    reg_read(8'h06, 8'h03);
    reg_read(8'h07, {REV, VEND});
    reg_read(8'h08, 8'h00);
    check(ctlVec, {7'h7F, 3'h7, 5'h1F, 1'h0, 2'h3, 4'h0}, "reset controls");
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int o = 2; o < 7; o++) begin
        i_host.put(8'h80 | o[7:0], p ? 8'h00 : 8'hFF, 1'b1);
        reg_read(o[7:0], p ? 8'h00 : (o == 2) ? 8'hF8 : (o == 6) ? 8'hB7 : 8'hFF);
      end
      check(ctlVec, p ? {7'h00, 3'h2, 5'h00, 1'h0, 2'h0, 4'h0}
        : {7'h7F, 3'h5, 5'h1F, 1'h1, 2'h3, 4'hF}, "field controls");
    end
    i_host.put(8'h87, 8'h00, 1'b1);
    reg_read(8'h07, {REV, VEND});
    i_host.put(8'h06, 8'h04, 1'b1);
    i_host.put(8'hA6, 8'h04, 1'b1);
    repeat (2) @(posedge clk);
    #1 check(spreadOn, 1'h0, "refused write");
    $display("test field access done");
    i_host.put(8'h83, 8'hFF, 1'b1);
    i_host.put(8'h84, 8'h3F, 1'b1);
    i_host.put(8'h85, 8'h40, 1'b1);
    bus_clock_halt_pin = 1'b0;
    repeat (6) @(posedge clk);
    #1 check({busClockRun, freerunBusClockRun}, 10'h000, "halted clocks");
    check({srcTrueOe, srcCompOe}, 2'h3, "ref pair driven in halt");
    check({cpuTrueOe[3], cpuCompOe[3]}, 2'h3, "pair 3 on");
    i_host.put(8'h84, 8'h07, 1'b1);
    repeat (2) @(posedge clk);
    #1 check(freerunBusClockRun, 3'h7, "free running under halt");
    i_host.put(8'h82, 8'h40, 1'b1);
    i_host.put(8'h85, 8'h00, 1'b1);
    repeat (2) @(posedge clk);
    #1 check({srcTrueOe, srcCompOe}, 2'h0, "ref pair floated in halt");
    check({cpuTrueOe[3], cpuCompOe[3]}, 2'h0, "pair 3 off");
    i_host.put(8'h82, 8'h00, 1'b1);
    bus_clock_halt_pin = 1'b1;
    power_down_pin = 1'b0;
    repeat (6) @(posedge clk);
    #1 check({freerunBusClockRun, srcTrueOe, srcCompOe, srcTrueHoldHigh, srcDoubleCurrent,
      cpuTrueOe[2:0], cpuCompOe[2:0], cpuTrueHoldHigh[2:0], cpuDoubleCurrent[2:0]},
      {3'h0, 4'hB, 12'hE3F}, "power down drive");
    i_host.put(8'h82, 8'hB8, 1'b1);
    repeat (3) @(posedge clk);
    #1 check({srcTrueOe, cpuTrueOe[2:0], cpuCompOe[2:0]}, 7'h00, "power down float");
    power_down_pin = 1'b1;
    $display("test pins done");
    close_out();
  end
endmodule // tb_top
bind clock_output_control_regs output_ctrl_monitor #(.REVISION_CODE(REVISION_CODE),
  .VENDOR_CODE(VENDOR_CODE), .BUS_CLOCKS(BUS_CLOCKS)) i_mon (.clk, .rst, .command,
  .writeStrobe, .writeData, .readStrobe, .readData, .readValid, .commandAccepted,
  .busClockEnable, .usbHighDrive, .video48Mode, .srcFreq200, .spreadOn);
`default_nettype wire
